// ===== aaac_pkg.sv
// constants shared by the acquisition arm/align controller and its group engines
// assumes a single 50 MHz clock and an apb register port
package aaac_pkg;
  // clock and timing
  localparam int unsigned CLK_HZ         = 50_000_000;
  localparam int unsigned DELAY_UNIT_MS  = 16;
  localparam int unsigned CYC_PER_UNIT   = (CLK_HZ / 1000) * DELAY_UNIT_MS;
  localparam int unsigned GROUPS         = 4;
  localparam int unsigned TRG_LINES      = 8;

  // widths
  localparam int unsigned ADDR_W         = 18;   // 262144 samples per channel
  localparam int unsigned DLY_W          = 37;   // 16 ms units, covers 1e9 s
  localparam int unsigned MS_W           = 40;   // requested delay in ms

  // register byte offsets
  localparam logic [7:0] OFS_CTRL        = 8'h00;
  localparam logic [7:0] OFS_ALIGN       = 8'h04;
  localparam logic [7:0] OFS_ARM         = 8'h08;
  localparam logic [7:0] OFS_DLY_LO      = 8'h0c;
  localparam logic [7:0] OFS_DLY_HI      = 8'h10;
  localparam logic [7:0] OFS_POINTS      = 8'h14;
  localparam logic [7:0] OFS_STATUS      = 8'h18;

  // ctrl fields
  localparam int unsigned CTRL_POL_BIT   = 0;
  localparam int unsigned CTRL_LINE_LSB  = 4;
  localparam logic        POL_RST        = 1'b0;  // negative
  localparam logic [3:0]  LINE_RST       = 4'h8;  // backplane align off
  localparam logic [3:0]  LINE_OFF       = 4'h8;
  localparam logic [3:0]  LINE_MIN       = 4'h1;

  // arm command fields
  localparam int unsigned ARM_MODE_LSB   = 4;
  localparam logic [3:0]  ARM_DEF_GROUPS = 4'h1;
  localparam logic [ADDR_W-1:0] POINTS_RST = 18'h00100;

  // status fields
  localparam int unsigned ST_EXT_BIT     = 16;
  localparam int unsigned ST_ALIGN_BIT   = 17;

  typedef enum logic [1:0] {
    ARM_IMMEDIATE  = 2'h0,
    ARM_DELAYED    = 2'h1,
    ARM_CONTINUOUS = 2'h2,
    ARM_STOP       = 2'h3
  } aaac_mode_t;
endpackage : aaac_pkg

// ===== aaac_grp_if.sv
// bundle between the controller and one channel-group engine
// assumes both ends run on ref_clk
`timescale 1ns/10ps
interface aaac_grp_if;
  logic                             arm;          // one-cycle arm/stop request
  aaac_pkg::aaac_mode_t             mode;         // mode with the request
  logic [aaac_pkg::DLY_W-1:0]       delay_units;  // rounded delay, 0 = none
  logic [aaac_pkg::ADDR_W-1:0]      points;       // post-trigger count
  logic                             tick16;       // 16 ms enable pulse
  logic                             sample_tick;  // gated sample enable
  logic                             trig_in;      // group trigger level
  logic                             busy;
  logic                             trig_en;
  logic                             done;
  logic                             mem_we;
  logic [aaac_pkg::ADDR_W-1:0]      mem_addr;

  modport ctrl (output arm, mode, delay_units, points, tick16, sample_tick, trig_in,
                input busy, trig_en, done, mem_we, mem_addr);
  modport grp  (input arm, mode, delay_units, points, tick16, sample_tick, trig_in,
                output busy, trig_en, done, mem_we, mem_addr);
endinterface : aaac_grp_if

// ===== aaac_group.sv
// one channel-group acquisition engine: delay, trigger arming, post-trigger fill
// assumes the controller delivers gated sample ticks and a free 16 ms tick
`timescale 1ns/10ps
module aaac_group (
  input wire logic  ref_clk,      // 50 MHz clock
  input wire logic  rst,          // synchronous reset
  aaac_grp_if.grp   g             // controller side
);
  typedef enum logic [2:0] {ST_IDLE, ST_DELAY, ST_ARMED, ST_POST, ST_FREE, ST_DONE} aaac_gstate_t;

  aaac_gstate_t                 state_q;
  logic [aaac_pkg::DLY_W-1:0]   dly_q;
  logic [aaac_pkg::ADDR_W-1:0]  post_q;
  logic [aaac_pkg::ADDR_W-1:0]  addr_q;
  logic                         we_q;
  logic                         filling;

  // memory is written in every acquiring state, triggered or not
  assign filling = (state_q == ST_DELAY) || (state_q == ST_ARMED) ||
                   (state_q == ST_POST) || (state_q == ST_FREE);

  // arming sequence and post-trigger countdown
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      dly_q   <= '0;
      post_q  <= '0;
    end else if (g.arm) begin
      post_q <= g.points;
      dly_q  <= g.delay_units;
      unique case (g.mode)
        aaac_pkg::ARM_IMMEDIATE:  state_q <= ST_ARMED;
        aaac_pkg::ARM_DELAYED:    state_q <= (g.delay_units == '0) ? ST_ARMED : ST_DELAY;
        aaac_pkg::ARM_CONTINUOUS: state_q <= ST_FREE;
        aaac_pkg::ARM_STOP:       state_q <= ST_IDLE;
      endcase
    end else begin
      unique case (state_q)
        ST_IDLE, ST_FREE, ST_DONE: state_q <= state_q;
        // triggers stay off until the last unit has fully passed
        ST_DELAY: if (g.tick16) begin
          if (dly_q == '0) state_q <= ST_ARMED;
          else dly_q <= dly_q - 1'b1;
        end
        // a trigger already high at arming goes straight to the post count
        ST_ARMED: if (g.trig_in) begin
          state_q <= (post_q == '0) ? ST_DONE : ST_POST;
        end
        ST_POST: if (g.sample_tick) begin
          if (post_q == 18'h00001) state_q <= ST_DONE;
          post_q <= post_q - 1'b1;
        end
      endcase
    end
  end

  // write strobe and address: stale samples beyond the post count are kept
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      we_q   <= 1'b0;
      addr_q <= '0;
    end else begin
      // the tick that meets the trigger in the armed state is not a post sample,
      // so a trigger already high at arming writes exactly the post count
      we_q <= filling && g.sample_tick && !(state_q == ST_ARMED && g.trig_in);
      if (we_q) addr_q <= addr_q + 1'b1;               // wraps over the full memory
    end
  end

  assign g.busy     = filling;
  assign g.trig_en  = (state_q == ST_ARMED) || (state_q == ST_POST);
  assign g.done     = (state_q == ST_DONE);
  assign g.mem_we   = we_q;
  assign g.mem_addr = addr_q;
endmodule : aaac_group

// ===== aaac_top.sv
// acquisition arm and clock-align controller for four channel groups
// assumes apb master on ref_clk, backplane and external lines already synchronous
//
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/10ps
module aaac_top #(
  parameter int unsigned CYC_PER_UNIT = aaac_pkg::CYC_PER_UNIT  // cycles per 16 ms
) (
  input  wire logic                  ref_clk,        // 50 MHz clock
  input  wire logic                  rst,            // synchronous reset, high
  input  wire logic                  psel,           // apb select
  input  wire logic                  penable,        // apb access phase
  input  wire logic                  pwrite,         // apb direction
  input  wire logic [7:0]            paddr,          // apb byte address
  input  wire logic [31:0]           pwdata,         // apb write data
  output logic      [31:0]           prdata,         // apb read data
  output logic                       pready,         // apb ready
  output logic                       pslverr,        // apb error, unmapped address
  input  wire logic                  ext_align_in,   // external align level
  input  wire logic [7:0]            bp_trig_in,     // backplane trigger lines 0..7
  input  wire logic [3:0]            sample_tick_in, // per-group sample enables
  input  wire logic [3:0]            group_trig_in,  // per-group trigger levels
  output logic      [3:0]            sample_en,      // gated sample enables
  output logic      [3:0]            sample_clk_rst, // per-group sample clock reset
  output logic                       align_out,      // internal align line
  output logic                       timetag_clr,    // time-tag counter clear
  output logic      [3:0]            mem_we,         // per-group memory write
  output logic      [71:0]           mem_addr        // four 18-bit write addresses
);
  localparam int unsigned G = aaac_pkg::GROUPS;

  logic                            pol_q;
  logic [3:0]                      line_q;
  logic                            imm_q;
  logic [31:0]                     dly_lo_q;
  logic [7:0]                      dly_hi_q;
  logic [aaac_pkg::ADDR_W-1:0]     points_q;
  logic [G-1:0]                    arm_q;
  aaac_pkg::aaac_mode_t            mode_q;
  logic [aaac_pkg::DLY_W-1:0]      dly_units_q;
  logic [31:0]                     prdata_q;
  logic                            align_q;
  logic [G-1:0]                    clk_rst_q;
  logic [31:0]                     pre_q;
  logic                            tick16_q;
  logic                            ext_active;
  logic                            bp_active;
  logic                            align_now;
  logic                            wr_en;
  logic                            rd_setup;
  logic                            mapped;
  logic [aaac_pkg::MS_W:0]         ms_sum;
  logic [3:0]                      arm_groups;
  logic [G-1:0]                    busy;
  logic [G-1:0]                    trig_en;
  logic [G-1:0]                    done;
  logic [31:0]                     status;

  // apb decode; the slave never waits, errors only on unmapped offsets
  assign mapped = (paddr == aaac_pkg::OFS_CTRL)   || (paddr == aaac_pkg::OFS_ALIGN) ||
                  (paddr == aaac_pkg::OFS_ARM)    || (paddr == aaac_pkg::OFS_DLY_LO) ||
                  (paddr == aaac_pkg::OFS_DLY_HI) || (paddr == aaac_pkg::OFS_POINTS) ||
                  (paddr == aaac_pkg::OFS_STATUS);
  assign wr_en    = psel && penable && pwrite && mapped;
  assign rd_setup = psel && !penable && !pwrite;
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !mapped;
  assign prdata   = prdata_q;

  // align configuration, applied on the write edge with no arm interlock
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pol_q  <= aaac_pkg::POL_RST;
      line_q <= aaac_pkg::LINE_RST;
    end else if (wr_en && paddr == aaac_pkg::OFS_CTRL) begin
      pol_q <= pwdata[aaac_pkg::CTRL_POL_BIT];
      // out-of-range values (0, 9..15) fall back to off
      if (pwdata[aaac_pkg::CTRL_LINE_LSB +: 4] >= aaac_pkg::LINE_MIN &&
          pwdata[aaac_pkg::CTRL_LINE_LSB +: 4] <= aaac_pkg::LINE_OFF)
        line_q <= pwdata[aaac_pkg::CTRL_LINE_LSB +: 4];
      else
        line_q <= aaac_pkg::LINE_OFF;
    end
  end

  // immediate align command: a single-cycle pulse per write
  always_ff @(posedge ref_clk) begin
    if (rst) imm_q <= 1'b0;
    else imm_q <= wr_en && (paddr == aaac_pkg::OFS_ALIGN) && pwdata[0];
  end

  // delay and sweep settings, held for the next arm command
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dly_lo_q <= '0;
      dly_hi_q <= '0;
      points_q <= aaac_pkg::POINTS_RST;
    end else if (wr_en) begin
      if (paddr == aaac_pkg::OFS_DLY_LO) dly_lo_q <= pwdata;
      if (paddr == aaac_pkg::OFS_DLY_HI) dly_hi_q <= pwdata[7:0];
      if (paddr == aaac_pkg::OFS_POINTS) points_q <= pwdata[aaac_pkg::ADDR_W-1:0];
    end
  end

  // ms to 16 ms units, rounding up; zero stays zero
  assign ms_sum = {1'b0, dly_hi_q, dly_lo_q} + 41'h000_0000_000f;

  // an empty group list means group 1 only
  assign arm_groups = (pwdata[3:0] == 4'h0) ? aaac_pkg::ARM_DEF_GROUPS : pwdata[3:0];

  // arm command fan-out; groups outside the list see no request
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      arm_q       <= '0;
      mode_q      <= aaac_pkg::ARM_IMMEDIATE;
      dly_units_q <= '0;
    end else begin
      arm_q <= '0;
      if (wr_en && paddr == aaac_pkg::OFS_ARM) begin
        arm_q       <= arm_groups;
        mode_q      <= aaac_pkg::aaac_mode_t'(pwdata[aaac_pkg::ARM_MODE_LSB +: 2]);
        dly_units_q <= ms_sum[aaac_pkg::MS_W:4];
      end
    end
  end

  // free 16 ms prescaler; arming mid-period makes the delay up to one unit longer
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pre_q    <= '0;
      tick16_q <= 1'b0;
    end else begin
      tick16_q <= (pre_q == CYC_PER_UNIT - 1);
      pre_q    <= (pre_q == CYC_PER_UNIT - 1) ? '0 : pre_q + 1'b1;
    end
  end

  // align sources; line 0 and the off code never match
  assign ext_active = (ext_align_in == pol_q);
  assign bp_active  = (line_q != aaac_pkg::LINE_OFF) && (line_q != 4'h0) &&
                      bp_trig_in[line_q[2:0]];
  assign align_now  = imm_q || ext_active || bp_active;

  // registered align line, time-tag clear and clock resets
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      align_q   <= 1'b0;
      clk_rst_q <= '0;
    end else begin
      align_q   <= align_now;
      // only groups that are acquiring get their divider restarted
      clk_rst_q <= {G{align_now}} & busy;
    end
  end
  assign align_out      = align_q;
  assign timetag_clr    = align_q;
  assign sample_clk_rst = clk_rst_q;
  // the external level is a master gate on every sampling clock
  assign sample_en      = ext_active ? '0 : sample_tick_in;

  // per-group engines
  genvar gi;
  generate
    for (gi = 0; gi < G; gi++) begin : g_grp
      aaac_grp_if gif ();
      assign gif.arm         = arm_q[gi];
      assign gif.mode        = mode_q;
      assign gif.delay_units = dly_units_q;
      assign gif.points      = points_q;
      assign gif.tick16      = tick16_q;
      // groups take the gated enables, so an active external align level stops their sampling
      assign gif.sample_tick = sample_en[gi];
      assign gif.trig_in     = group_trig_in[gi];
      assign busy[gi]        = gif.busy;
      assign trig_en[gi]     = gif.trig_en;
      assign done[gi]        = gif.done;
      assign mem_we[gi]      = gif.mem_we;
      assign mem_addr[gi*aaac_pkg::ADDR_W +: aaac_pkg::ADDR_W] = gif.mem_addr;
      aaac_group u_grp (
        .ref_clk (ref_clk),
        .rst     (rst),
        .g       (gif.grp)
      );
    end
  endgenerate

  // status word: per group nibble busy/trigger-enabled/done, plus align levels
  always_comb begin
    status = '0;
    for (int i = 0; i < G; i++) begin
      status[4*i]   = busy[i];
      status[4*i+1] = trig_en[i];
      status[4*i+2] = done[i];
    end
    status[aaac_pkg::ST_EXT_BIT]   = ext_active;
    status[aaac_pkg::ST_ALIGN_BIT] = align_q;
  end

  // read data captured in the setup cycle, stable through the access cycle
  always_ff @(posedge ref_clk) begin
    if (rst) prdata_q <= '0;
    else if (rd_setup) begin
      unique case (paddr)
        aaac_pkg::OFS_CTRL:   prdata_q <= {24'h000000, line_q, 3'h0, pol_q};
        aaac_pkg::OFS_DLY_LO: prdata_q <= dly_lo_q;
        aaac_pkg::OFS_DLY_HI: prdata_q <= {24'h000000, dly_hi_q};
        aaac_pkg::OFS_POINTS: prdata_q <= {14'h0000, points_q};
        aaac_pkg::OFS_STATUS: prdata_q <= status;
        default:              prdata_q <= '0;   // write-only and unmapped read zero
      endcase
    end
  end
endmodule : aaac_top

// ===== aaac_assertions.sv
// port checker for the arm/align controller
// assumes binding to aaac_top, one clock, synchronous reset
`timescale 1ns/10ps
module aaac_assertions #(
  parameter int unsigned CYC_PER_UNIT = aaac_pkg::CYC_PER_UNIT  // cycles per 16 ms
) (
  input wire logic        ref_clk,        // clock
  input wire logic        rst,            // reset
  input wire logic        psel,           // apb select
  input wire logic        penable,        // access phase
  input wire logic        pwrite,         // direction
  input wire logic [7:0]  paddr,          // address
  input wire logic [31:0] pwdata,         // write data
  input wire logic [31:0] prdata,         // read data
  input wire logic        pready,         // ready
  input wire logic        pslverr,        // error
  input wire logic        ext_align_in,   // external align
  input wire logic [7:0]  bp_trig_in,     // backplane lines
  input wire logic [3:0]  sample_tick_in, // raw ticks
  input wire logic [3:0]  group_trig_in,  // triggers
  input wire logic [3:0]  sample_en,      // gated ticks
  input wire logic [3:0]  sample_clk_rst, // clock resets
  input wire logic        align_out,      // align line
  input wire logic        timetag_clr,    // tag clear
  input wire logic [3:0]  mem_we,         // write strobes
  input wire logic [71:0] mem_addr        // write addresses
);
  logic       pol_q;
  logic [3:0] line_q;
  logic [1:0] imm_q;
  logic       wr_ctrl;
  logic       wr_imm;
  logic       src_act;
  // mirrored ctrl so source checks need no design internals
  assign wr_ctrl = psel && penable && pwrite && pready && paddr == 8'h00;
  assign wr_imm  = psel && penable && pwrite && pready && paddr == 8'h04 && pwdata[0];
  assign src_act = (ext_align_in == pol_q) || (line_q != 4'h8 && bp_trig_in[line_q[2:0]]);
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pol_q  <= 1'b0;
      line_q <= 4'h8;
    end else if (wr_ctrl) begin
      pol_q  <= pwdata[0];
      line_q <= (pwdata[7:4] == 4'h0 || pwdata[7:4] > 4'h8) ? 4'h8 : pwdata[7:4];
    end
  end
  // recent pulse commands, masks the quiet-line check
  always_ff @(posedge ref_clk) begin
    if (rst)
      imm_q <= 2'h0;
    else
      imm_q <= {imm_q[0], wr_imm};
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_gate_ext: assert property (sample_en == ((ext_align_in == pol_q) ? 4'h0 : sample_tick_in))
    else $error("sample enables not gated by external level");
  a_src_align: assert property (src_act |=> align_out)
    else $error("align line missed an active source");
  a_quiet_line: assert property (!src_act && !wr_imm && imm_q == 2'h0 |=> !align_out)
    else $error("align line high with no source");
  a_imm_pulse: assert property (wr_imm |-> ##[2:3] align_out)
    else $error("pulse command gave no align");
  a_tag_clear: assert property (timetag_clr == align_out)
    else $error("time tag clear differs from align");
  a_clk_reset: assert property (sample_clk_rst != 4'h0 |-> align_out)
    else $error("sample clock reset without align");
  a_err_map: assert property (psel && penable && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 8'h18))
    else $error("slave error on wrong address");
  a_err_phase: assert property (pslverr |-> psel && penable)
    else $error("slave error outside access");
  a_we_tick: assert property (mem_we != 4'h0 |-> (mem_we & ~$past(sample_en)) == 4'h0)
    else $error("memory write without gated tick");
  a_addr_step: assert property (mem_we[0] |=> mem_addr[17:0] == $past(mem_addr[17:0]) + 18'h1)
    else $error("group address did not step");
endmodule : aaac_assertions
bind aaac_top aaac_assertions #(.CYC_PER_UNIT(CYC_PER_UNIT)) aaac_assertions_inst (
  .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .ext_align_in(ext_align_in), .bp_trig_in(bp_trig_in), .sample_tick_in(sample_tick_in),
  .group_trig_in(group_trig_in), .sample_en(sample_en), .sample_clk_rst(sample_clk_rst),
  .align_out(align_out), .timetag_clr(timetag_clr), .mem_we(mem_we), .mem_addr(mem_addr)
);

// ===== aaac_host_model.sv
// host model issuing register commands over apb
// assumes one clock; a request starts just after a rising edge
`timescale 1ns/10ps
module aaac_host_model (
  input  wire logic        ref_clk, // clock
  output logic             psel,    // select
  output logic             penable, // access phase
  output logic             pwrite,  // direction
  output logic [7:0]       paddr,   // address
  output logic [31:0]      pwdata,  // write data
  input  wire logic [31:0] prdata,  // read data
  input  wire logic        pready,  // ready
  input  wire logic        pslverr  // error
);
  int n_hang = 0;
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
  end
  // one transfer, held until pready is seen; bounded so a dead slave is counted
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
      n_hang++;
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~a;  // released lines never show the old value
    pwdata  <= ~d;
  endtask : xfer
endmodule : aaac_host_model

// ===== tb_acquisition_arm_align_control.sv
// self-checking bench for the arm/align controller
// assumes the host model drives apb, the bench drives ticks, triggers and align lines
`timescale 1ns/10ps
module tb_acquisition_arm_align_control;
  typedef struct packed {
    logic [7:0]  addr;  // byte address
    logic [31:0] wdata; // written first
    logic [31:0] rdata; // expected read
    logic        err;   // expected error
  } aaac_row_t;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, err, align_out, timetag_clr;
  logic ext_align_in = 1'b0;
  logic [7:0] paddr;
  logic [7:0] bp_trig_in = 8'h00;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] sample_tick_in = 4'hf;
  logic [3:0] group_trig_in = 4'h0;
  logic [3:0] sample_en, sample_clk_rst, mem_we;
  logic [71:0] mem_addr;
  int n_fail = 0;
  int checks = 0;
  int n, na, nr, nx;
  aaac_row_t rows [6] = '{
    '{8'h00, 32'h71, 32'h71, 1'b0}, '{8'h00, 32'h00, 32'h80, 1'b0},
    '{8'h00, 32'h90, 32'h80, 1'b0}, '{8'h04, 32'h00, 32'h00, 1'b0},
    '{8'h14, 32'h05, 32'h05, 1'b0}, '{8'h1c, 32'h01, 32'h00, 1'b1}};
  always #10 ref_clk = ~ref_clk;
  aaac_top #(.CYC_PER_UNIT(20)) aaac_top_inst (
    .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_align_in(ext_align_in), .bp_trig_in(bp_trig_in), .sample_tick_in(sample_tick_in),
    .group_trig_in(group_trig_in), .sample_en(sample_en), .sample_clk_rst(sample_clk_rst),
    .align_out(align_out), .timetag_clr(timetag_clr), .mem_we(mem_we), .mem_addr(mem_addr));
  aaac_host_model aaac_host_model_inst (
    .ref_clk(ref_clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  task automatic chk_word(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk_word
  task automatic chk_cnt(input string nm, input int lo, input int hi, input int got);
    checks++;
    if (got < lo || got > hi) begin
      n_fail++;
      $display("ERROR %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask : chk_cnt
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    aaac_host_model_inst.xfer(1'b1, a, d, rd, err);
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    aaac_host_model_inst.xfer(1'b0, a, 32'h0, rd, err);
  endtask : rdr
  // counts strobes of group g, cycles with align high, clock resets of group g and stray group activity
  task automatic watch(input int g, input int cyc);
    n = 0;
    na = 0;
    nr = 0;
    nx = 0;
    repeat (cyc) begin
      @(posedge ref_clk);
      n += (mem_we[g] === 1'b1);
      na += (align_out === 1'b1);
      nr += (sample_clk_rst[g] === 1'b1);
      nx += (((mem_we | sample_clk_rst) & ~(4'h1 << g)) !== 4'h0);
    end
  endtask : watch
  task automatic tally_and_finish;
    n_fail += aaac_host_model_inst.n_hang;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    rdr(8'h00);
    chk_word("ctrl reset", 32'h80, rd);
    rdr(8'h14);
    chk_word("points reset", 32'h100, rd);
    chk_word("gated at reset", 32'h0, {28'h0, sample_en});
    chk_word("align at reset", 32'h1, {31'h0, align_out});
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wdata);
      rdr(rows[i].addr);
      chk_word("read back", rows[i].rdata, rd);
      chk_word("slave error", {31'h0, rows[i].err}, {31'h0, err});
    end
    // awkward cases: polarity flip, gating, pulse, line values 0 to 8
    wr(8'h00, 32'h81);
    @(posedge ref_clk);
    chk_word("ticks pass", 32'hf, {28'h0, sample_en});
    ext_align_in <= 1'b1;
    watch(0, 3);
    chk_word("ticks gated", 32'h0, {28'h0, sample_en});
    chk_cnt("ext align", 2, 3, na);
    ext_align_in <= 1'b0;
    watch(0, 3);
    wr(8'h04, 32'h1);
    watch(0, 6);
    chk_cnt("imm pulse", 1, 1, na);
    for (int l = 0; l < 9; l++) begin
      wr(8'h00, {24'h0, l[3:0], 4'h1});
      bp_trig_in <= (l < 8) ? 8'h01 << l : 8'hff;
      @(posedge ref_clk);
      bp_trig_in <= 8'h00;
      watch(0, 5);
      chk_cnt("line align", l % 8 != 0, l % 8 != 0, na);
    end
    wr(8'h14, 32'h3);
    group_trig_in <= 4'hf;
    wr(8'h08, 32'h0);
    watch(0, 20);
    chk_cnt("post count", 3, 3, n);
    chk_cnt("other groups", 0, 0, nx);
    wr(8'h08, 32'h4);
    watch(2, 20);
    chk_cnt("group three count", 3, 3, n);
    chk_cnt("group three only", 0, 0, nx);
    rdr(8'h18);
    chk_word("status done", 32'h404, rd);
    wr(8'h14, 32'h2);
    for (int k = 0; k < 2; k++) begin
      wr(8'h0c, k);
      wr(8'h10, 32'h0);
      wr(8'h08, 32'h11);
      rdr(8'h18);
      chk_word("delay trig enable", k ? 32'h401 : 32'h403, rd);
      watch(0, 60);
      chk_cnt("delayed fill", k ? 22 : 2, k ? 41 : 2, n);
    end
    wr(8'h08, 32'h21);
    wr(8'h04, 32'h1);
    watch(0, 30);
    chk_cnt("free running", 25, 30, n);
    chk_cnt("busy clock reset", 1, 2, nr);
    chk_cnt("idle clock reset", 0, 0, nx);
    wr(8'h08, 32'h31);
    watch(0, 5);
    watch(0, 20);
    chk_cnt("stopped", 0, 0, n);
    // second reset in mid-run: addresses and settings go back to reset values
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    chk_word("addr after reset", 32'h0, {31'h0, |mem_addr});
    rdr(8'h00);
    chk_word("ctrl after reset", 32'h80, rd);
    tally_and_finish();
  end
endmodule : tb_acquisition_arm_align_control
